// File: ssm_pkg.sv
// Notes on behaviour
// - Modes 000/001/010 master at clock/4,/16,/64; 011 timebase; 100 half timer match.
// - Mode 101 is SPI slave; 110 is the I2C slave; 111 unused.
// - Peripheral clock pin driven only when enabled; divider picks clock, /4, /8, match/2.
// - Interface off: pins released, engine held in a quiet idle state.
// - The on bit works only when the module option selects the serial function.
// - Turning on in SPI modes leaves SPI control contents unchanged.
// - Turning on in I2C mode keeps direction/ack out, resets I2C status flags.
// - Bit 0 of the mode/enable register reads as zero.
// - Top two format bits are plain read/write storage.
// - Idle clock level high when clk_idle_low is 0, low when 1.
// - Capture rising when capture_edge_sel equals clk_idle_low, otherwise falling.
// - msb_first 1 shifts MSB first; 0 shifts LSB first.
// - select_pin_en 1 uses the select pin; 0 releases it.
// - An option decides whether select_pin_en takes effect.
// - Data write during a transfer is discarded and sets write_collision.
// - An option decides whether collision detection is available.
// - Hardware sets xfer_done at transfer end; only software clears it.
// - Master mode, enabled: writing shift_data starts a full-duplex exchange.
// - Slave: each received clock shifts data out and serial_in in.
// - SPI keeps running in the controller's idle mode.
// - Slave, on, select pin disabled: always selected, select level ignored.
// - All transmit and receive data pass through the single shift_data register.
`default_nettype none
package ssm_pkg;
    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [3:0] ADDR_DATA = 4'h0;
    localparam logic [3:0] ADDR_MODE = 4'h4;
    localparam logic [3:0] ADDR_FMT = 4'h8;
    localparam logic [3:0] ADDR_I2C = 4'hC;
    localparam logic [7:0] MODE_RESET = 8'hE0;
    localparam logic [7:0] FMT_RESET = 8'h00;
    localparam logic [7:0] DATA_RESET = 8'h00;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int MODE_ON = 1;
    localparam int MODE_PCK_LO = 2;
    localparam int MODE_PCK_EN = 4;
    localparam int MODE_SEL_LO = 5;
    localparam int FMT_DONE = 0;
    localparam int FMT_WRITE_COLLISION = 1;
    localparam int FMT_SELEN = 2;
    localparam int FMT_MSB = 3;
    localparam int FMT_EDGE = 4;
    localparam int FMT_IDLE = 5;
    localparam int I2C_ACK_OUT = 3;
    localparam int I2C_TX_DIR = 4;
    // i2c flags: done, addr match, busy, read req, ack in
    localparam logic [4:0] I2C_FLAGS_RESET = 5'h11;
    // ------------------------------------------------------------
    // mode codes and clock divisions (half periods in clocks)
    // ------------------------------------------------------------
    localparam logic [2:0] M_DIV4 = 3'h0;
    localparam logic [2:0] M_DIV16 = 3'h1;
    localparam logic [2:0] M_DIV64 = 3'h2;
    localparam logic [2:0] M_TBC = 3'h3;
    localparam logic [2:0] M_TMR = 3'h4;
    localparam logic [2:0] M_SLAVE = 3'h5;
    localparam logic [2:0] M_I2C = 3'h6;
    localparam logic [5:0] HALF_DIV4 = 6'h02;
    localparam logic [5:0] HALF_DIV16 = 6'h08;
    localparam logic [5:0] HALF_DIV64 = 6'h20;
    localparam logic [1:0] PCK_SYS = 2'h0;
    localparam logic [1:0] PCK_DIV4 = 2'h1;
    localparam logic [1:0] PCK_DIV8 = 2'h2;
    localparam logic [1:0] PCK_TMR = 2'h3;
    localparam logic [5:0] HALF_PCK4 = 6'h02;
    localparam logic [5:0] HALF_PCK8 = 6'h04;
    // ------------------------------------------------------------
    // transfer length: two clock edges per bit, eight bits
    // ------------------------------------------------------------
    localparam logic [3:0] LAST_EDGE = 4'hF;
    localparam logic [3:0] FIRST_EDGE = 4'h0;
endpackage
`default_nettype wire

// File: ssm_tick_div.sv
`default_nettype none
module ssm_tick_div
    import ssm_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic run,
    input wire logic [5:0] half_cycles,
    output logic tick
);
    logic [5:0] count;
    logic at_end;

    // end of one half period
    assign at_end = (count == half_cycles - 6'h01);
    assign tick = run && at_end;

    // free counter, parked at zero while stopped
    always_ff @(posedge clk) begin
        if (rst || !run || at_end) begin
            count <= 6'h00;
        end else begin
            count <= count + 6'h01;
        end
    end
endmodule
`default_nettype wire

// File: ssm_top.sv
`default_nettype none
module ssm_top
    import ssm_pkg::*;
(
    input wire logic MCLK,
    input wire logic RESET,
    input wire logic [3:0] S_AXI_AWADDR,
    input wire logic S_AXI_AWVALID,
    output logic S_AXI_AWREADY,
    input wire logic [31:0] S_AXI_WDATA,
    input wire logic [3:0] S_AXI_WSTRB,
    input wire logic S_AXI_WVALID,
    output logic S_AXI_WREADY,
    output logic [1:0] S_AXI_BRESP,
    output logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    input wire logic [3:0] S_AXI_ARADDR,
    input wire logic S_AXI_ARVALID,
    output logic S_AXI_ARREADY,
    output logic [31:0] S_AXI_RDATA,
    output logic [1:0] S_AXI_RRESP,
    output logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY,
    input wire logic CFG_SERIAL_MODULE,
    input wire logic CFG_SELECT_PIN,
    input wire logic CFG_WRITE_COLLISION,
    input wire logic TIMEBASE_CLK,
    input wire logic TIMER0_PERIOD_MATCH,
    input wire logic SERIAL_CLOCK_IN,
    output logic SERIAL_CLOCK_OUT,
    output logic SERIAL_CLOCK_OE,
    input wire logic SERIAL_IN,
    output logic SERIAL_OUT,
    output logic SERIAL_OUT_OE,
    input wire logic SLAVE_SELECT_N_IN,
    output logic SLAVE_SELECT_N_OUT,
    output logic SLAVE_SELECT_N_OE,
    output logic PERIPH_CLK_PIN,
    output logic PERIPH_CLK_OE
);
    // ------------------------------------------------------------
    // registers and engine state
    // ------------------------------------------------------------
    logic [7:0] mode_reg;
    logic [7:0] fmt;
    logic [7:0] shift_data;
    logic [1:0] i2c_ctl;
    logic [4:0] i2c_flags;
    logic on_q;
    logic busy;
    logic [3:0] edge_cnt;
    logic sck;
    logic samp;
    logic sck_in_q;
    logic tb_q;
    logic pck_div;
    logic aw_held;
    logic w_held;
    logic [3:0] wr_addr;
    logic [7:0] wr_data;
    logic wr_strb0;

    logic [2:0] sim_mode_sel;
    logic serial_if_on;
    logic periph_clk_out_en;
    logic [1:0] periph_clk_out_div;
    logic clk_idle_low;
    logic capture_edge_sel;
    logic msb_first;
    logic select_pin_en;
    logic active;
    logic is_master;
    logic is_slave;
    logic sel_eff;
    logic selected;
    logic idle_lvl;
    logic div_tick;
    logic pck_tick;
    logic tb_edge;
    logic m_tick;
    logic s_edge;
    logic ev;
    logic lead;
    logic sample_now;
    logic shift_now;
    logic last;
    logic shift_bit;
    logic do_wr;
    logic hit_data;
    logic hit_mode;
    logic hit_fmt;
    logic hit_i2c;
    logic on_rise;
    logic collide;
    logic [5:0] spi_half;
    logic [7:0] next_shift;
    logic [7:0] rd_mux;

    // ------------------------------------------------------------
    // decoded fields
    // ------------------------------------------------------------
    assign sim_mode_sel = mode_reg[MODE_SEL_LO +: 3];
    assign serial_if_on = mode_reg[MODE_ON];
    assign periph_clk_out_en = mode_reg[MODE_PCK_EN];
    assign periph_clk_out_div = mode_reg[MODE_PCK_LO +: 2];
    assign clk_idle_low = fmt[FMT_IDLE];
    assign capture_edge_sel = fmt[FMT_EDGE];
    assign msb_first = fmt[FMT_MSB];
    assign select_pin_en = fmt[FMT_SELEN];

    // mode decode; on bit gated by the module option
    assign active = serial_if_on && CFG_SERIAL_MODULE;
    assign is_master = active && (sim_mode_sel <= M_TMR);
    assign is_slave = active && (sim_mode_sel == M_SLAVE);
    assign sel_eff = select_pin_en && CFG_SELECT_PIN;
    // slave always selected when the select pin is not in use
    assign selected = !sel_eff || !SLAVE_SELECT_N_IN;
    assign idle_lvl = !clk_idle_low;

    // ------------------------------------------------------------
    // master clock sources; dividers stop between transfers
    // ------------------------------------------------------------
    always_comb begin
        unique case (sim_mode_sel)
            M_DIV16: spi_half = HALF_DIV16;
            M_DIV64: spi_half = HALF_DIV64;
            default: spi_half = HALF_DIV4;
        endcase
    end

    ssm_tick_div u_spi_div (
        .clk(MCLK),
        .rst(RESET),
        .run(busy && is_master && (sim_mode_sel <= M_DIV64)),
        .half_cycles(spi_half),
        .tick(div_tick)
    );

    assign tb_edge = TIMEBASE_CLK ^ tb_q;

    // one clock edge per source event: full rate halves for timer
    always_comb begin
        m_tick = 1'b0;
        if (busy && is_master) begin
            if (sim_mode_sel == M_TBC) begin
                m_tick = tb_edge;
            end else if (sim_mode_sel == M_TMR) begin
                m_tick = TIMER0_PERIOD_MATCH;
            end else begin
                m_tick = div_tick;
            end
        end
    end

    // slave sees edges of the external clock while selected
    assign s_edge = is_slave && selected && (SERIAL_CLOCK_IN ^ sck_in_q);
    assign ev = m_tick || s_edge;
    // leading edge moves the line away from its idle level
    assign lead = is_master ? (sck == idle_lvl) :
                              (SERIAL_CLOCK_IN != idle_lvl);
    // capture on leading edge exactly when capture_edge_sel is set
    assign sample_now = (lead == capture_edge_sel);
    assign last = (edge_cnt == LAST_EDGE);
    // late-capture modes skip the shift on the very first edge
    assign shift_now = ev && (!sample_now || last) &&
                       !(edge_cnt == FIRST_EDGE && !capture_edge_sel);
    // final edge of a late-capture transfer takes the pin directly
    assign shift_bit = (sample_now && last) ? SERIAL_IN : samp;
    assign next_shift = msb_first ? {shift_data[6:0], shift_bit} :
                                    {shift_bit, shift_data[7:1]};

    // ------------------------------------------------------------
    // bus slave: write path
    // ------------------------------------------------------------
    assign S_AXI_AWREADY = !aw_held && !S_AXI_BVALID;
    assign S_AXI_WREADY = !w_held && !S_AXI_BVALID;
    assign do_wr = aw_held && w_held && !S_AXI_BVALID;
    assign hit_data = do_wr && wr_strb0 && (wr_addr == ADDR_DATA);
    assign hit_mode = do_wr && wr_strb0 && (wr_addr == ADDR_MODE);
    assign hit_fmt = do_wr && wr_strb0 && (wr_addr == ADDR_FMT);
    assign hit_i2c = do_wr && wr_strb0 && (wr_addr == ADDR_I2C);
    assign collide = hit_data && busy;

    // address and data halves held until both are present
    always_ff @(posedge MCLK) begin
        if (RESET || do_wr) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
        end else begin
            if (S_AXI_AWVALID && S_AXI_AWREADY) begin
                aw_held <= 1'b1;
            end
            if (S_AXI_WVALID && S_AXI_WREADY) begin
                w_held <= 1'b1;
            end
        end
    end

    always_ff @(posedge MCLK) begin
        if (RESET) begin
            wr_addr <= 4'h0;
            wr_data <= 8'h00;
            wr_strb0 <= 1'b0;
        end else begin
            if (S_AXI_AWVALID && S_AXI_AWREADY) begin
                wr_addr <= S_AXI_AWADDR;
            end
            if (S_AXI_WVALID && S_AXI_WREADY) begin
                wr_data <= S_AXI_WDATA[7:0];
                wr_strb0 <= S_AXI_WSTRB[0];
            end
        end
    end

    // write response, error for an address that is not word aligned
    always_ff @(posedge MCLK) begin
        if (RESET) begin
            S_AXI_BVALID <= 1'b0;
            S_AXI_BRESP <= RESP_OKAY;
        end else if (do_wr) begin
            S_AXI_BVALID <= 1'b1;
            S_AXI_BRESP <= (wr_addr[1:0] != 2'h0) ? RESP_SLVERR : RESP_OKAY;
        end else if (S_AXI_BREADY) begin
            S_AXI_BVALID <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // bus slave: read path
    // ------------------------------------------------------------
    assign S_AXI_ARREADY = !S_AXI_RVALID;

    always_comb begin
        unique case (S_AXI_ARADDR)
            ADDR_DATA: rd_mux = shift_data;
            ADDR_MODE: rd_mux = {mode_reg[7:1], 1'b0};
            ADDR_FMT: rd_mux = fmt;
            ADDR_I2C: rd_mux = {i2c_flags[4:2], i2c_ctl, i2c_flags[1],
                                1'b0, i2c_flags[0]};
            default: rd_mux = 8'h00;
        endcase
    end

    always_ff @(posedge MCLK) begin
        if (RESET) begin
            S_AXI_RVALID <= 1'b0;
            S_AXI_RDATA <= 32'h0000_0000;
            S_AXI_RRESP <= RESP_OKAY;
        end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
            S_AXI_RVALID <= 1'b1;
            S_AXI_RDATA <= {24'h00_0000, rd_mux};
            S_AXI_RRESP <= (S_AXI_ARADDR[1:0] != 2'h0) ? RESP_SLVERR :
                                                         RESP_OKAY;
        end else if (S_AXI_RREADY) begin
            S_AXI_RVALID <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // control registers
    // ------------------------------------------------------------
    // mode/enable register; bit 0 never stored
    always_ff @(posedge MCLK) begin
        if (RESET) begin
            mode_reg <= MODE_RESET;
        end else if (hit_mode) begin
            mode_reg <= {wr_data[7:1], 1'b0};
        end
    end

    // format register; hardware set wins over a software write
    // turning on leaves these settings alone
    always_ff @(posedge MCLK) begin
        if (RESET) begin
            fmt <= FMT_RESET;
        end else begin
            if (hit_fmt) begin
                fmt <= wr_data;
            end
            if (collide && CFG_WRITE_COLLISION) begin
                fmt[FMT_WRITE_COLLISION] <= 1'b1;
            end
            if (ev && last) begin
                fmt[FMT_DONE] <= 1'b1;
            end
        end
    end

    // i2c side: control kept, status back to defaults on turn-on in I2C mode
    assign on_rise = active && !on_q;
    always_ff @(posedge MCLK) begin
        if (RESET) begin
            on_q <= 1'b0;
            i2c_ctl <= 2'h0;
            i2c_flags <= I2C_FLAGS_RESET;
        end else begin
            on_q <= active;
            if (hit_i2c) begin
                i2c_ctl <= {wr_data[I2C_TX_DIR], wr_data[I2C_ACK_OUT]};
            end
            if (on_rise && sim_mode_sel == M_I2C) begin
                i2c_flags <= I2C_FLAGS_RESET;
            end
        end
    end

    // ------------------------------------------------------------
    // shift engine; no gating by the controller idle mode
    // ------------------------------------------------------------
    always_ff @(posedge MCLK) begin
        if (RESET) begin
            sck_in_q <= 1'b0;
            tb_q <= 1'b0;
            samp <= 1'b0;
        end else begin
            sck_in_q <= SERIAL_CLOCK_IN;
            tb_q <= TIMEBASE_CLK;
            if (ev && sample_now) begin
                samp <= SERIAL_IN;
            end
        end
    end

    // single data register shared by software and shifter
    always_ff @(posedge MCLK) begin
        if (RESET) begin
            shift_data <= DATA_RESET;
        end else if (hit_data && !busy) begin
            shift_data <= wr_data;
        end else if (shift_now) begin
            shift_data <= next_shift;
        end
    end

    // transfer state and edge count, sixteen edges per byte
    always_ff @(posedge MCLK) begin
        if (RESET || !(is_master || is_slave)) begin
            busy <= 1'b0;
            edge_cnt <= FIRST_EDGE;
        end else if (is_slave && !selected) begin
            busy <= 1'b0;
            edge_cnt <= FIRST_EDGE;
        end else if (ev) begin
            busy <= !last;
            edge_cnt <= edge_cnt + 4'h1;
        end else if (hit_data && !busy && is_master) begin
            busy <= 1'b1;
        end
    end

    // master clock line, parked at idle between transfers
    always_ff @(posedge MCLK) begin
        if (RESET) begin
            sck <= 1'b1;
        end else if (!busy || !is_master) begin
            sck <= idle_lvl;
        end else if (m_tick) begin
            sck <= !sck;
        end
    end

    // ------------------------------------------------------------
    // peripheral clock output
    // ------------------------------------------------------------
    ssm_tick_div u_pck_div (
        .clk(MCLK),
        .rst(RESET),
        .run(periph_clk_out_en && (periph_clk_out_div == PCK_DIV4 ||
             periph_clk_out_div == PCK_DIV8)),
        .half_cycles((periph_clk_out_div == PCK_DIV8) ? HALF_PCK8 :
                     HALF_PCK4),
        .tick(pck_tick)
    );

    always_ff @(posedge MCLK) begin
        if (RESET || !periph_clk_out_en) begin
            pck_div <= 1'b0;
        end else if (pck_tick || (periph_clk_out_div == PCK_TMR &&
                                  TIMER0_PERIOD_MATCH)) begin
            pck_div <= !pck_div;
        end
    end

    // ------------------------------------------------------------
    // pins
    // ------------------------------------------------------------
    assign PERIPH_CLK_OE = periph_clk_out_en;
    assign PERIPH_CLK_PIN = periph_clk_out_en &&
        ((periph_clk_out_div == PCK_SYS) ? MCLK : pck_div);
    assign SERIAL_CLOCK_OUT = sck;
    assign SERIAL_CLOCK_OE = is_master;
    assign SERIAL_OUT = msb_first ? shift_data[7] : shift_data[0];
    assign SERIAL_OUT_OE = is_master || (is_slave && selected);
    assign SLAVE_SELECT_N_OUT = !busy;
    assign SLAVE_SELECT_N_OE = is_master && sel_eff;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge MCLK);
    endclocking
    default disable iff (RESET);

    sequence s_fast_edge;
        is_master && sim_mode_sel == M_DIV4 && busy && $changed(sck);
    endsequence

    sequence s_write_data_busy;
        hit_data && busy;
    endsequence

    a_collision_flag: assert property (
        s_write_data_busy ##0 CFG_WRITE_COLLISION |=> fmt[FMT_WRITE_COLLISION])
        else $error("collision flag not set");
    a_collision_discard: assert property (
        s_write_data_busy ##0 !shift_now |=> $stable(shift_data))
        else $error("write during transfer stored");
    a_done_flag: assert property (
        ev && last |=> fmt[FMT_DONE] && !busy)
        else $error("done flag missing at transfer end");
    a_idle_clock: assert property (
        is_master && !busy ##1 is_master && !busy |->
        SERIAL_CLOCK_OUT == !$past(clk_idle_low))
        else $error("master clock not at idle level");
    a_mode_bit0: assert property (
        S_AXI_ARVALID && S_AXI_ARREADY && S_AXI_ARADDR == ADDR_MODE
        |=> S_AXI_RVALID && !S_AXI_RDATA[0])
        else $error("mode register bit 0 not zero");
    a_pck_off: assert property (
        !periph_clk_out_en |-> !PERIPH_CLK_OE && !PERIPH_CLK_PIN)
        else $error("peripheral clock driven while off");
    a_master_start: assert property (
        is_master && sim_mode_sel == M_DIV4 && hit_data && !busy |=>
        busy ##[1:4] $changed(sck))
        else $error("master write did not start transfer");
    a_off_quiet: assert property (
        !active |-> (!SERIAL_CLOCK_OE && !SERIAL_OUT_OE &&
        !SLAVE_SELECT_N_OE) ##1 !busy)
        else $error("pins driven while interface off");
    a_div4_rate: assert property (
        s_fast_edge |=> $stable(sck) ##1 ($changed(sck) || !busy))
        else $error("divide by four half period wrong");
    a_upper_store: assert property (
        hit_fmt |=> fmt[7:6] == $past(wr_data[7:6]))
        else $error("upper format bits not stored");
endmodule
`default_nettype wire

// File: ssm_slave_model.sv
`default_nettype none
module ssm_slave_model (
    input wire logic sclk,
    input wire logic sel_n,
    input wire logic mosi,
    input wire logic idle,
    input wire logic [7:0] tx,
    output logic miso,
    output logic [7:0] rx
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] sh;
    initial miso = 1'b0;
    // load the reply byte once selected
    always @(negedge sel_n) sh = tx;
    // released line shows the inverse of the last bit
    always @(posedge sel_n) miso = ~miso;
    // leading edge drives msb first, trailing edge captures
    always @(sclk) begin
        if (!sel_n && sclk !== idle) begin
            miso = sh[7];
            sh = {sh[6:0], 1'b0};
        end else if (!sel_n) begin
            rx = {rx[6:0], mosi};
        end
    end
endmodule
`default_nettype wire

// File: tb_top.sv
`default_nettype none
`define CHK(n, e, s) begin check_count++; if ((s) !== (e)) begin \
    err_count++; $display("Error %s exp %h got %h", n, e, s); end end
module tb_top;
    import ssm_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 0, rst = 1, awv = 0, wv = 0, bq = 0, arv = 0, rq = 0;
    logic [3:0] awa = 0, ara = 0;
    logic [31:0] wd = 0;
    logic cfg = 1, sck_in = 0, slv = 0, idle = 0, miso;
    logic [7:0] tx = 8'h35, rx, v;
    logic aw_r, w_r, b_v, ar_r, r_v, sck, sck_oe, serial_out, sdo_oe, ss, ss_oe;
    logic [1:0] br, rr;
    logic periph_clk_pin, ssn = 1;
    wire sdo_d, sel_d;
    // far side sees pins just after the edge that moves them
    assign #1 sdo_d = serial_out;
    assign #1 sel_d = ss_oe ? ss : 1'b1;
    logic [31:0] rd;
    int err_count = 0, check_count = 0, cyc = 0;
    // ------------------------------------------------------------
    // clock, design and far-side slave
    // ------------------------------------------------------------
    always #5 clk = ~clk;
    ssm_top u_dut (.MCLK(clk), .RESET(rst), .S_AXI_AWADDR(awa),
        .S_AXI_AWVALID(awv), .S_AXI_AWREADY(aw_r), .S_AXI_WDATA(wd),
        .S_AXI_WSTRB(4'h1), .S_AXI_WVALID(wv), .S_AXI_WREADY(w_r),
        .S_AXI_BRESP(br), .S_AXI_BVALID(b_v), .S_AXI_BREADY(bq),
        .S_AXI_ARADDR(ara), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(ar_r),
        .S_AXI_RDATA(rd), .S_AXI_RRESP(rr), .S_AXI_RVALID(r_v),
        .S_AXI_RREADY(rq), .CFG_SERIAL_MODULE(cfg), .CFG_SELECT_PIN(1'b1),
        .CFG_WRITE_COLLISION(1'b1), .TIMEBASE_CLK(1'b0),
        .TIMER0_PERIOD_MATCH(1'b0), .SERIAL_CLOCK_IN(sck_in),
        .SERIAL_CLOCK_OUT(sck), .SERIAL_CLOCK_OE(sck_oe),
        .SERIAL_IN(slv ? 1'b1 : miso), .SERIAL_OUT(serial_out),
        .SERIAL_OUT_OE(sdo_oe), .SLAVE_SELECT_N_IN(ssn),
        .SLAVE_SELECT_N_OUT(ss), .SLAVE_SELECT_N_OE(ss_oe),
        .PERIPH_CLK_PIN(periph_clk_pin), .PERIPH_CLK_OE(v[0]));
    ssm_slave_model u_slave (.sclk(sck), .sel_n(sel_d),
        .mosi(sdo_d), .idle(~idle), .tx(tx), .miso(miso), .rx(rx));
    // ------------------------------------------------------------
    // bus tasks
    // ------------------------------------------------------------
    task automatic wr(input logic [3:0] a, input logic [7:0] d,
                      input logic [1:0] er);
        @(posedge clk);
        awa <= a; wd <= {24'h00_0000, d}; awv <= 1; wv <= 1; bq <= 1;
        do begin
            @(posedge clk);
            if (aw_r) awv <= 0;
            if (w_r) wv <= 0;
        end while (b_v !== 1'b1);
        bq <= 0;
        `CHK("bresp", er, br)
    endtask
    task automatic rdchk(input logic [3:0] a, input logic [7:0] e,
                         input logic [1:0] er, input logic m);
        @(posedge clk);
        ara <= a; arv <= 1; rq <= 1;
        do begin
            @(posedge clk);
            if (ar_r) arv <= 0;
        end while (r_v !== 1'b1);
        rq <= 0;
        `CHK("rresp", er, rr)
        if (m) `CHK("rdata", e, rd[7:0])
    endtask
    task automatic xfer(input logic [7:0] d, input logic [7:0] f);
        wr(ADDR_DATA, d, RESP_OKAY);
        wr(ADDR_DATA, 8'h3C, RESP_OKAY);
        do rdchk(ADDR_FMT, 0, RESP_OKAY, 0); while (rd[0] !== 1'b1);
        `CHK("flags", f, rd[7:0])
        `CHK("idle clock", ~idle, sck)
    endtask
    task automatic report_and_stop;
        if (err_count == 0 && check_count > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    // ------------------------------------------------------------
    // watchdog
    // ------------------------------------------------------------
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            err_count++;
            report_and_stop();
        end
    end
    // ------------------------------------------------------------
    // test sequence
    // ------------------------------------------------------------
    initial begin
        repeat (12) @(posedge clk);
        rst <= 0;
        rdchk(ADDR_MODE, MODE_RESET, RESP_OKAY, 1);
        rdchk(4'h2, 0, RESP_SLVERR, 0);
        wr(ADDR_MODE, 8'hFD, RESP_OKAY);
        rdchk(ADDR_MODE, 8'hFC, RESP_OKAY, 1);
        wr(4'h1, 8'hFF, RESP_SLVERR);
        wr(ADDR_FMT, 8'hCC, RESP_OKAY);
        wr(ADDR_MODE, 8'h12, RESP_OKAY);
        rdchk(ADDR_FMT, 8'hCC, RESP_OKAY, 1);
        `CHK("master oe", 1'b1, sck_oe)
        `CHK("pck oe", 1'b1, v[0])
        `CHK("idle high", 1'b1, sck)
        #2 `CHK("pck pin", clk, periph_clk_pin)
        xfer(8'hA5, 8'hCF);
        `CHK("slave rx", 8'hA5, rx)
        rdchk(ADDR_DATA, 8'h35, RESP_OKAY, 1);
        idle <= 1;
        wr(ADDR_FMT, 8'h24, RESP_OKAY);
        @(posedge clk);
        `CHK("idle low", 1'b0, sck)
        xfer(8'h12, 8'h27);
        `CHK("lsb rx", 8'h48, rx)
        rdchk(ADDR_DATA, 8'hAC, RESP_OKAY, 1);
        cfg <= 0;
        repeat (2) @(posedge clk);
        `CHK("option off", 1'b0, sck_oe)
        cfg <= 1;
        sck_in <= 0;
        slv <= 1;
        wr(ADDR_FMT, 8'h20, RESP_OKAY);
        wr(ADDR_MODE, 8'hA2, RESP_OKAY);
        `CHK("slave oe", 1'b0, sck_oe)
        repeat (16) begin
            repeat (4) @(posedge clk);
            sck_in <= ~sck_in;
        end
        repeat (4) @(posedge clk);
        rdchk(ADDR_FMT, 8'h21, RESP_OKAY, 1);
        rdchk(ADDR_DATA, 8'hFF, RESP_OKAY, 1);
        wr(ADDR_FMT, 8'h24, RESP_OKAY);
        `CHK("deselected", 1'b0, sdo_oe)
        ssn <= 0;
        @(posedge clk);
        `CHK("selected", 1'b1, sdo_oe)
        wr(ADDR_MODE, 8'h00, RESP_OKAY);
        `CHK("off oe", 1'b0, sdo_oe)
        report_and_stop();
    end
endmodule
`default_nettype wire
